// file: video_insertion_regs.vh
// Register offsets, field positions and reset values for the insertion control bank
`ifndef VIDEO_INSERTION_REGS_VH
`define VIDEO_INSERTION_REGS_VH
`define ADDR_W 12
`define DATA_W 16
`define ADDR_FEATURE_DISABLES 12'h000
`define ADDR_RESERVED_ONE 12'h001
`define ADDR_EDH_FLAGS 12'h002
`define ADDR_FORMAT_A 12'h00a
`define ADDR_FORMAT_B 12'h00b
`define ADDR_LINE_FIELD_ONE 12'h01b
`define ADDR_LINE_FIELD_TWO 12'h01c
`define BIT_PAYLOAD_DIS 6
`define BIT_BADCODE_DIS 5
`define BIT_ERRPKT_DIS 4
`define BIT_ANCSUM_DIS 3
`define BIT_LINECRC_DIS 2
`define BIT_LINENUM_DIS 1
`define BIT_TIMREF_DIS 0
`define DISABLE_MASK 16'h007f
`define EDH_ERROR_FLAGS_MASK 16'hffff
`define LINE_MASK 16'h07ff
`define LINE_W 11
`define ANC_FLAG_HI 14
`define ANC_FLAG_LO 10
`define FF_FLAG_HI 9
`define FF_FLAG_LO 5
`define AP_FLAG_HI 4
`define AP_FLAG_LO 0
`define RESET_WORD 16'h0000
`define LINE_RESET 11'h000
`define FLAG_W 5
`define FLAG_RESET 5'h00
`define BIT_RESET 1'b0
`endif

// file: insertion_gate.v
// Combines disable bits, video mode and format registers into feature enables
`include "video_insertion_regs.vh"
module insertion_gate (
	input wire [`DATA_W-1:0] disables, // Feature disable word
	input wire [`DATA_W-1:0] formatA, // Payload bytes 1 and 2
	input wire [`DATA_W-1:0] formatB, // Payload bytes 3 and 4
	input wire hdMode, // High for HD, low for SD
	output wire payloadLumaEn, // Payload packet into luma
	output wire badCodeFixEn, // Illegal code correction
	output wire errorPacketEn, // Error packet generation
	output wire ancChecksumEn, // Ancillary checksum insertion
	output wire lineCrcEn, // Line CRC into luma and chroma
	output wire lineNumberEn, // Line number into luma and chroma
	output wire timingRefEn // Timing reference insertion
);
	// RULE1 HD luma gating
	wire formatNonZero = (|formatA) | (|formatB);
	// RULE2 payload disable
	assign payloadLumaEn = hdMode & formatNonZero & ~disables[`BIT_PAYLOAD_DIS];
	// RULE3 remap disable
	assign badCodeFixEn = ~disables[`BIT_BADCODE_DIS];
	// RULE4 SD error packets
	assign errorPacketEn = ~hdMode & ~disables[`BIT_ERRPKT_DIS];
	// RULE5 checksum disable
	assign ancChecksumEn = ~disables[`BIT_ANCSUM_DIS];
	// RULE6 HD line CRC
	assign lineCrcEn = hdMode & ~disables[`BIT_LINECRC_DIS];
	// RULE7 HD line numbers
	assign lineNumberEn = hdMode & ~disables[`BIT_LINENUM_DIS];
	// RULE8 timing reference disable
	assign timingRefEn = ~disables[`BIT_TIMREF_DIS];
endmodule

// file: video_insertion_control_regs.v
// Host register bank steering the insertion and correction features
// Functional notes
// RULE1 - HD only: payload packet into luma when either format register is non-zero.
// RULE2 - Payload packet insertion is suppressed while disable bit 6 is high.
// RULE3 - Illegal code correction in active picture runs unless bit 5 is high.
// RULE4 - SD only: error packets generated and inserted unless bit 4 is high.
// RULE5 - Ancillary checksums inserted unless bit 3 is high.
// RULE6 - HD only: line CRC into luma and chroma unless bit 2 is high.
// RULE7 - HD only: line numbers into luma and chroma unless bit 1 is high.
// RULE8 - Timing reference words inserted unless bit 0 is high.
// RULE9 - SD only: ancillary flag group bits 14 to 10 go into error packets.
// RULE10 - SD only: full-field flag group bits 9 to 5 go into error packets.
// RULE11 - SD only: active-picture flag group bits 4 to 0 go into error packets.
// RULE12 - After reset all disable bits and flags read zero.
// RULE13 - Every documented bit is host readable and writable as documented.
// RULE14 - Host programs payload bytes 1,2 in format A and 3,4 in format B.
// RULE15 - Payload packet goes on the line numbers held for field 1 and field 2.
`include "video_insertion_regs.vh"
module video_insertion_control_regs (
	input wire clock, // 100 MHz system clock
	input wire rst_n, // Asynchronous reset, active low
	input wire regWrite, // One-cycle write strobe from serial control
	input wire regRead, // One-cycle read strobe from serial control
	input wire [`ADDR_W-1:0] regAddr, // Register address
	input wire [`DATA_W-1:0] regWdata, // Write data
	input wire hdMode, // High in HD mode, low in SD mode
	input wire [`LINE_W-1:0] currentLine, // Line number of current video line
	input wire fieldTwo, // High during field 2
	output reg [`DATA_W-1:0] regRdata, // Read data, valid cycle after regRead
	output reg payloadLumaEn, // Payload packet insertion in luma
	output reg payloadLineHit, // Current line is the payload line
	output reg badCodeFixEn, // Illegal code correction enable
	output reg errorPacketEn, // Error packet generation enable
	output reg ancChecksumEn, // Ancillary checksum enable
	output reg lineCrcEn, // Line CRC insertion enable
	output reg lineNumberEn, // Line number insertion enable
	output reg timingRefEn, // Timing reference insertion enable
	output reg [4:0] ancFlags, // Ancillary flags for error packet
	output reg [4:0] fieldFlags, // Full-field flags for error packet
	output reg [4:0] pictureFlags // Active-picture flags for error packet
);
	reg [`DATA_W-1:0] disables_q;
	reg [`DATA_W-1:0] edhFlags_q;
	reg [`DATA_W-1:0] formatA_q;
	reg [`DATA_W-1:0] formatB_q;
	reg [`LINE_W-1:0] lineOne_q;
	reg [`LINE_W-1:0] lineTwo_q;
	reg [`DATA_W-1:0] readData_d;
	wire payloadEn, fixEn, errEn, csumEn, crcEn, numEn, trsEn;
	wire wrDisables, wrFlags, wrFormatA, wrFormatB, wrLineOne, wrLineTwo;
	wire [`LINE_W-1:0] payloadLine;
	wire lineMatch;

	function hit;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] b;
		hit = (a == b);
	endfunction

	// Line registers read back zero-extended to a full word
	function [`DATA_W-1:0] widenLine;
		input [`LINE_W-1:0] value;
		widenLine = {{(`DATA_W-`LINE_W){1'b0}}, value};
	endfunction

	// HD packets carry no error flags, so the groups read zero there
	function [`FLAG_W-1:0] sdGroup;
		input hd;
		input [`FLAG_W-1:0] group;
		sdGroup = hd ? `FLAG_RESET : group;
	endfunction

	// One strobe per register keeps the write paths apart
	assign wrDisables = regWrite & hit(regAddr, `ADDR_FEATURE_DISABLES);
	assign wrFlags = regWrite & hit(regAddr, `ADDR_EDH_FLAGS);
	assign wrFormatA = regWrite & hit(regAddr, `ADDR_FORMAT_A);
	assign wrFormatB = regWrite & hit(regAddr, `ADDR_FORMAT_B);
	assign wrLineOne = regWrite & hit(regAddr, `ADDR_LINE_FIELD_ONE);
	assign wrLineTwo = regWrite & hit(regAddr, `ADDR_LINE_FIELD_TWO);

	// RULE12 zero after reset
	// RULE13 disable bits writable
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			disables_q <= `RESET_WORD;
		end else if (wrDisables) begin
			// Bits above 6 steer features outside this bank and stay zero
			disables_q <= regWdata & `DISABLE_MASK;
		end
	end

	// RULE12 zero after reset
	// RULE13 flag word writable
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			edhFlags_q <= `RESET_WORD;
		end else if (wrFlags) begin
			edhFlags_q <= regWdata & `EDH_ERROR_FLAGS_MASK;
		end
	end

	// RULE13 format word writable
	// RULE14 payload bytes 1 and 2
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			formatA_q <= `RESET_WORD;
		end else if (wrFormatA) begin
			formatA_q <= regWdata;
		end
	end

	// RULE13 format word writable
	// RULE14 payload bytes 3 and 4
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			formatB_q <= `RESET_WORD;
		end else if (wrFormatB) begin
			formatB_q <= regWdata;
		end
	end

	// RULE13 line word writable
	// RULE15 field 1 payload line
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lineOne_q <= `LINE_RESET;
		end else if (wrLineOne) begin
			lineOne_q <= regWdata[`LINE_W-1:0];
		end
	end

	// RULE13 line word writable
	// RULE15 field 2 payload line
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lineTwo_q <= `LINE_RESET;
		end else if (wrLineTwo) begin
			lineTwo_q <= regWdata[`LINE_W-1:0];
		end
	end

	// RULE13 host read path
	always @* begin
		readData_d = `RESET_WORD;
		case (regAddr)
			`ADDR_FEATURE_DISABLES: readData_d = disables_q;
			`ADDR_EDH_FLAGS: readData_d = edhFlags_q;
			`ADDR_FORMAT_A: readData_d = formatA_q;
			`ADDR_FORMAT_B: readData_d = formatB_q;
			`ADDR_LINE_FIELD_ONE: readData_d = widenLine(lineOne_q);
			`ADDR_LINE_FIELD_TWO: readData_d = widenLine(lineTwo_q);
			default: readData_d = `RESET_WORD;
		endcase
	end

	insertion_gate insertion_gate_inst (
		.disables(disables_q),
		.formatA(formatA_q),
		.formatB(formatB_q),
		.hdMode(hdMode),
		.payloadLumaEn(payloadEn),
		.badCodeFixEn(fixEn),
		.errorPacketEn(errEn),
		.ancChecksumEn(csumEn),
		.lineCrcEn(crcEn),
		.lineNumberEn(numEn),
		.timingRefEn(trsEn)
	);

	// Read word is held until the next read strobe
	// RULE13 host read capture
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= `RESET_WORD;
		end else if (regRead) begin
			regRdata <= readData_d;
		end
	end

	// RULE15 field line select
	assign payloadLine = fieldTwo ? lineTwo_q : lineOne_q;
	assign lineMatch = (currentLine == payloadLine);

	// Registered enables; a write shows here one edge after it lands
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			payloadLumaEn <= `BIT_RESET;
			payloadLineHit <= `BIT_RESET;
			badCodeFixEn <= `BIT_RESET;
			errorPacketEn <= `BIT_RESET;
			ancChecksumEn <= `BIT_RESET;
			lineCrcEn <= `BIT_RESET;
			lineNumberEn <= `BIT_RESET;
			timingRefEn <= `BIT_RESET;
		end else begin
			// RULE1 RULE2 payload gating
			payloadLumaEn <= payloadEn;
			// RULE15 payload line match
			payloadLineHit <= payloadEn & lineMatch;
			// RULE3 correction enable
			badCodeFixEn <= fixEn;
			// RULE4 error packet enable
			errorPacketEn <= errEn;
			// RULE5 checksum enable
			ancChecksumEn <= csumEn;
			// RULE6 line CRC enable
			lineCrcEn <= crcEn;
			// RULE7 line number enable
			lineNumberEn <= numEn;
			// RULE8 timing reference enable
			timingRefEn <= trsEn;
		end
	end

	// Flag groups for the error packet builder
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ancFlags <= `FLAG_RESET;
			fieldFlags <= `FLAG_RESET;
			pictureFlags <= `FLAG_RESET;
		end else begin
			// RULE9 ancillary group, SD only
			ancFlags <= sdGroup(hdMode, edhFlags_q[`ANC_FLAG_HI:`ANC_FLAG_LO]);
			// RULE10 full-field group, SD only
			fieldFlags <= sdGroup(hdMode, edhFlags_q[`FF_FLAG_HI:`FF_FLAG_LO]);
			// RULE11 active-picture group, SD only
			pictureFlags <= sdGroup(hdMode, edhFlags_q[`AP_FLAG_HI:`AP_FLAG_LO]);
		end
	end
endmodule

// file: video_insertion_control_regs_monitor.sv
// Port checker for the insertion control bank
`include "video_insertion_regs.vh"
module video_insertion_control_regs_monitor (
	input wire logic clock, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic regWrite, // Write strobe
	input wire logic regRead, // Read strobe
	input wire logic hdMode, // High for HD
	input wire logic [`ADDR_W-1:0] regAddr, // Address
	input wire logic [`DATA_W-1:0] regWdata, // Write data
	input wire logic [`DATA_W-1:0] regRdata, // Read data
	input wire logic payloadLumaEn, // Payload enable
	input wire logic badCodeFixEn, // Correction enable
	input wire logic errorPacketEn, // Error packet enable
	input wire logic ancChecksumEn, // Checksum enable
	input wire logic lineCrcEn, // Line CRC enable
	input wire logic lineNumberEn, // Line number enable
	input wire logic timingRefEn, // Timing reference enable
	input wire logic [4:0] ancFlags, // Ancillary flags
	input wire logic [4:0] fieldFlags, // Full-field flags
	input wire logic [4:0] pictureFlags // Active-picture flags
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic wrDis = regWrite && regAddr == `ADDR_FEATURE_DISABLES;
	// Write lands in two edges: register, then output flop
	property p_payload; wrDis && regWdata[6] |-> ##2 !payloadLumaEn; endproperty
	a_payload: assert property (p_payload) else $error("payload not suppressed");
	property p_hdOnly; !hdMode |=> !payloadLumaEn && !lineCrcEn && !lineNumberEn; endproperty
	a_hdOnly: assert property (p_hdOnly) else $error("HD feature on in SD");
	property p_sdOnly; hdMode |=> !errorPacketEn && {ancFlags, fieldFlags, pictureFlags} == 15'h0; endproperty
	a_sdOnly: assert property (p_sdOnly) else $error("SD feature on in HD");
	property p_remap; wrDis |-> ##2 badCodeFixEn == !$past(regWdata[5], 2); endproperty
	a_remap: assert property (p_remap) else $error("remap enable wrong");
	property p_trs; wrDis |-> ##2 timingRefEn == !$past(regWdata[0], 2); endproperty
	a_trs: assert property (p_trs) else $error("timing ref enable wrong");
	property p_crc; wrDis && hdMode ##1 hdMode |=> lineCrcEn == !$past(regWdata[2], 2); endproperty
	a_crc: assert property (p_crc) else $error("line crc enable wrong");
	property p_flags; regWrite && regAddr == `ADDR_EDH_FLAGS ##1 !hdMode
		|=> {ancFlags, fieldFlags, pictureFlags} == $past(regWdata[14:0], 2); endproperty
	a_flags: assert property (p_flags) else $error("flag groups wrong");
	property p_rst; $rose(rst_n) |-> regRdata == 16'h0000 && !payloadLumaEn; endproperty
	a_rst: assert property (p_rst) else $error("not clear after reset");
endmodule
bind video_insertion_control_regs video_insertion_control_regs_monitor
	video_insertion_control_regs_monitor_inst (.*);

// file: host_model.sv
// Host model issuing single word transfers
`include "video_insertion_regs.vh"
module host_model (
	input wire logic clock, // Clock
	input wire logic [`DATA_W-1:0] regRdata, // Read data
	output logic regWrite = 1'b0, // Write strobe
	output logic regRead = 1'b0, // Read strobe
	output logic [`ADDR_W-1:0] regAddr = 12'h000, // Address
	output logic [`DATA_W-1:0] regWdata = 16'h0000 // Write data
);
	timeunit 1ns;
	timeprecision 1ps;
	// whole words; released lines invert so stale data never matches
	task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
		@(posedge clock);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clock);
		regWrite <= 1'b0;
		regAddr <= ~a;
		regWdata <= ~d;
	endtask
	task automatic rd(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] d);
		@(posedge clock);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'b0;
		regAddr <= ~a;
		@(posedge clock);
		#1 d = regRdata;
	endtask
endmodule

// file: test_video_insertion_control_regs.sv
// Self-checking bench for the insertion control bank
`include "video_insertion_regs.vh"
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin nFail++; \
	$display("wrong value at %0t: got %h want %h", $time, a, b); end end
`define HW host_model_inst.wr
`define HR host_model_inst.rd
module test_video_insertion_control_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, rst_n = 1'b0, hdMode = 1'b0, fieldTwo = 1'b0, regWrite, regRead;
	logic payloadLumaEn, payloadLineHit, badCodeFixEn, errorPacketEn, ancChecksumEn;
	logic lineCrcEn, lineNumberEn, timingRefEn;
	logic [`ADDR_W-1:0] regAddr;
	logic [`DATA_W-1:0] regWdata, regRdata, rdv;
	logic [`LINE_W-1:0] currentLine = 11'h000;
	logic [4:0] ancFlags, fieldFlags, pictureFlags;
	int nFail = 0, cmpCount = 0, cyc = 0;
	video_insertion_control_regs video_insertion_control_regs_inst (.*);
	host_model host_model_inst (.*);
	always #5 clock = ~clock;
	task results;
		$display("compares %0d, mismatches %0d", cmpCount, nFail);
		if (nFail == 0 && cmpCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 4000) begin
			nFail++;
			results;
		end
	end
	task settle;
		repeat (3) @(posedge clock);
		#1;
	endtask
	task t_reset;
		`HR(`ADDR_FEATURE_DISABLES, rdv);
		`CHK(rdv, `RESET_WORD)
		`HR(`ADDR_EDH_FLAGS, rdv);
		`CHK(rdv, `RESET_WORD)
		`CHK({errorPacketEn, timingRefEn, payloadLumaEn}, 3'b110)
	endtask
	task t_disables;
		logic [6:0] w, g;
		`HW(`ADDR_FORMAT_A, 16'h0001);
		for (int m = 0; m < 2; m++) begin
			for (int i = 0; i < 8; i++) begin
				w = 7'h01 << i;
				@(posedge clock) hdMode <= m[0];
				`HW(`ADDR_FEATURE_DISABLES, {9'h1ff, w});
				settle;
				g = {m[0], 1'b1, !m[0], 1'b1, m[0], m[0], 1'b1};
				`CHK({payloadLumaEn, badCodeFixEn, errorPacketEn, ancChecksumEn, lineCrcEn,
					lineNumberEn, timingRefEn}, ~w & g)
			end
		end
		`HW(`ADDR_FEATURE_DISABLES, 16'hffff);
		`HR(`ADDR_FEATURE_DISABLES, rdv);
		`CHK(rdv, `DISABLE_MASK)
	endtask
	task t_flags;
		@(posedge clock) hdMode <= 1'b0;
		`HW(`ADDR_EDH_FLAGS, 16'hb5a3);
		for (int m = 0; m < 2; m++) begin
			@(posedge clock) hdMode <= ~m[0];
			settle;
			`CHK({ancFlags, fieldFlags, pictureFlags}, m ? 15'h35a3 : 15'h0000)
		end
		`HR(`ADDR_EDH_FLAGS, rdv);
		`CHK(rdv, 16'hb5a3)
	endtask
	task t_payload;
		@(posedge clock) hdMode <= 1'b1;
		`HW(`ADDR_FEATURE_DISABLES, 16'h0000);
		`HW(`ADDR_FORMAT_A, 16'h0000);
		settle;
		`CHK(payloadLumaEn, 1'b0)
		`HW(`ADDR_FORMAT_B, 16'h8000);
		`HW(`ADDR_LINE_FIELD_ONE, 16'hf805);
		`HW(`ADDR_LINE_FIELD_TWO, 16'h0009);
		`HR(`ADDR_LINE_FIELD_ONE, rdv);
		`CHK(rdv, 16'h0005)
		for (int f = 0; f < 2; f++) begin
			@(posedge clock) fieldTwo <= f[0];
			currentLine <= f ? 11'h009 : 11'h005;
			settle;
			`CHK({payloadLumaEn, payloadLineHit}, 2'b11)
			@(posedge clock) currentLine <= 11'h007;
			settle;
			`CHK(payloadLineHit, 1'b0)
		end
		`HW(`ADDR_RESERVED_ONE, 16'hffff);
		`HR(`ADDR_RESERVED_ONE, rdv);
		`CHK(rdv, 16'h0000)
	endtask
	task t_rerun;
		`HW(`ADDR_FEATURE_DISABLES, 16'h007f);
		`HW(`ADDR_EDH_FLAGS, 16'hffff);
		@(posedge clock) rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		`HR(`ADDR_FEATURE_DISABLES, rdv);
		`CHK(rdv, `RESET_WORD)
		`HR(`ADDR_EDH_FLAGS, rdv);
		`CHK(rdv, `RESET_WORD)
		`CHK({badCodeFixEn, ancChecksumEn, timingRefEn}, 3'b111)
	endtask
	initial begin
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		t_reset;
		t_disables;
		t_flags;
		t_payload;
		t_rerun;
		results;
	end
endmodule
